/* cie_defines.svh */
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
// Register byte offsets, decoded on haddr[7:0].
`define CIE_OFF_CTRL 8'h00
`define CIE_OFF_IDT 8'h04
`define CIE_OFF_STAT 8'h08
`define CIE_OFF_RET 8'h0c
// Control register fields.
`define CIE_CTRL_IF 0
`define CIE_CTRL_PM 1
// Status register fields.
`define CIE_STAT_VEC_LSB 0
`define CIE_STAT_NMIA 8
`define CIE_STAT_NMIP 9
`define CIE_STAT_BADV 10
`define CIE_STAT_CLS_LSB 11
// Position of the interrupt-enable bit inside the flags word.
`define CIE_FLAGS_IF 9
// Fixed vectors.
`define CIE_VEC_NMI 8'h02
`define CIE_VEC_BRK 8'h03
`define CIE_VEC_DF 8'h08
`define CIE_VEC_CSO 8'h09
`define CIE_VEC_USER_MIN 8'h21
// Table entry size as a shift: 4 bytes real mode, 8 bytes protected.
`define CIE_RM_SHIFT 2
`define CIE_PM_SHIFT 3
// Reset values.
`define CIE_RST_IF 1'b0
`define CIE_RST_PM 1'b0
`define CIE_RST_IDT 32'h0000_0000
`define CIE_HSIZE_WORD 3'h2
`endif

/* cie_pkg.sv */
package cie_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_ACK, ST_FETCH, ST_GO} cie_state_type;
   typedef enum logic [1:0] {EXC_FAULT, EXC_TRAP, EXC_ABORT, EXC_MASKABLE_IRQ_INPUT} cie_class_type;
   typedef enum logic [1:0] {GATE_MASKABLE_IRQ_INPUT, GATE_TRAP, GATE_TASK} cie_gate_type;
   typedef struct packed {
      cie_state_type st;
      logic if_flag;
      logic pmode;
      logic [31:0] idt_base;
      logic [1:0] nmi_sync;
      logic nmi_prev;
      logic [1:0] irq_sync;
      logic [1:0] ackv_sync;
      logic ackv_prev;
      logic [7:0] vec_s1;
      logic [7:0] vec_s2;
      logic nmi_active;
      logic nmi_pending;
      logic bad_vec;
      logic is_nmi;
      logic [7:0] cur_vec;
      cie_class_type cur_class;
      logic [31:0] ret_ip;
      logic push_req;
      logic [31:0] push_flags;
      logic inta;
      logic table_req;
      logic [31:0] table_addr;
      logic go;
      logic [31:0] go_handler;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic a_wr;
      logic [7:0] a_addr;
   } cie_state_reg_type;
endpackage

/* cie_unit.sv */
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_unit
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic instr_boundary,
   input wire logic string_window,
   input wire logic [31:0] cur_ip,
   input wire logic [31:0] next_ip,
   input wire logic [31:0] flags_word,
   input wire logic trap_req,
   input wire logic [7:0] trap_vec,
   input wire logic trap_sw,
   input wire logic break_req,
   input wire logic fault_req,
   input wire logic [7:0] fault_vec,
   input wire logic interrupt_return_op_req,
   input wire logic [31:0] interrupt_return_op_flags,
   input wire logic table_valid,
   input wire cie_pkg::cie_gate_type table_gate,
   input wire logic [31:0] table_task_flags,
   input wire logic [31:0] table_handler,
   input wire logic nmi_pin,
   input wire logic maskable_irq_input,
   input wire logic intack_valid,
   input wire logic [7:0] intack_vector,
   output logic push_req,
   output logic [31:0] push_ip,
   output logic [31:0] push_flags,
   output logic inta,
   output logic table_req,
   output logic [31:0] table_addr,
   output logic handler_go,
   output logic [31:0] handler_addr,
   output logic [7:0] handler_vec,
   output cie_pkg::cie_class_type handler_class,
   output logic if_flag
);
   import cie_pkg::*;

   cie_state_reg_type r;
   cie_state_reg_type n;
   logic bnd;
   logic nmi_edge;
   logic nmi_ok;
   logic maskable_irq_input_ok;
   logic ackv_rise;
   logic idle_take;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Entry address: base plus vector scaled by the entry size of the mode.
   function automatic logic [31:0] tbl_addr(input logic [31:0] base,
                                            input logic [7:0] v,
                                            input logic pm);
      logic [31:0] off;
      off = pm ? ({24'h0, v} << `CIE_PM_SHIFT) : ({24'h0, v} << `CIE_RM_SHIFT);
      return base + off;
   endfunction

   // Class of an exception from its vector and the path that raised it.
   function automatic cie_class_type classify(input logic [7:0] v,
                                              input logic is_fault,
                                              input logic is_sw);
      if (is_sw)
      begin
         return EXC_TRAP;
      end
      if (v == `CIE_VEC_DF || v == `CIE_VEC_CSO)
      begin
         return EXC_ABORT;
      end
      return is_fault ? EXC_FAULT : EXC_TRAP;
   endfunction

   // Register read multiplexer; unmapped offsets read as zero.
   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input cie_state_reg_type s);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         `CIE_OFF_CTRL:
         begin
            d[`CIE_CTRL_IF] = s.if_flag;
            d[`CIE_CTRL_PM] = s.pmode;
         end
         `CIE_OFF_IDT: d = s.idt_base;
         `CIE_OFF_STAT:
         begin
            d[`CIE_STAT_VEC_LSB +: 8] = s.cur_vec;
            d[`CIE_STAT_NMIA] = s.nmi_active;
            d[`CIE_STAT_NMIP] = s.nmi_pending;
            d[`CIE_STAT_BADV] = s.bad_vec;
            d[`CIE_STAT_CLS_LSB +: 2] = s.cur_class;
         end
         `CIE_OFF_RET: d = s.ret_ip;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Recognition terms; pins read through synchronisers, boundary and return requests read direct.

   assign bnd = instr_boundary | string_window;
   assign nmi_edge = r.nmi_sync[1] & ~r.nmi_prev;
   assign nmi_ok = r.nmi_pending & ~r.nmi_active;
   assign maskable_irq_input_ok = r.irq_sync[1] & r.if_flag & ~r.nmi_active;
   assign ackv_rise = r.ackv_sync[1] & ~r.ackv_prev;
   assign idle_take = (r.st == ST_IDLE) & ~interrupt_return_op_req & bnd;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole unit.

   always_comb
   begin
      n = r;
      n.nmi_sync = {r.nmi_sync[0], nmi_pin};
      n.nmi_prev = r.nmi_sync[1];
      n.irq_sync = {r.irq_sync[0], maskable_irq_input};
      n.ackv_sync = {r.ackv_sync[0], intack_valid};
      n.ackv_prev = r.ackv_sync[1];
      n.vec_s1 = intack_vector;
      n.vec_s2 = r.vec_s1;
      n.push_req = 1'b0;
      n.table_req = 1'b0;
      n.go = 1'b0;
      n.hready = 1'b1;
      n.hresp = 1'b0;
      // Data phase of a write; hardware updates below override software.
      if (r.a_wr)
      begin
         unique case (r.a_addr)
            `CIE_OFF_CTRL:
            begin
               n.if_flag = hwdata[`CIE_CTRL_IF];
               n.pmode = hwdata[`CIE_CTRL_PM];
            end
            `CIE_OFF_IDT: n.idt_base = hwdata;
            `CIE_OFF_STAT:
            begin
               if (hwdata[`CIE_STAT_BADV])
               begin
                  n.bad_vec = 1'b0;
               end
            end
            default: n.a_wr = 1'b0;
         endcase
      end
      // Address phase; read data is fetched now so it stands in the data phase.
      n.a_wr = 1'b0;
      n.hrdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready)
      begin
         n.a_addr = haddr[7:0];
         n.a_wr = hwrite && (hsize == `CIE_HSIZE_WORD);
         if (!hwrite)
         begin
            n.hrdata = rd_mux(haddr[7:0], r);
         end
      end
      unique case (r.st)
         ST_IDLE:
         begin
            // Return restores the enable flag from the popped flags word.
            if (interrupt_return_op_req)
            begin
               n.if_flag = interrupt_return_op_flags[`CIE_FLAGS_IF];
               n.nmi_active = 1'b0;
            end
            else if (bnd)
            begin
               // Traps of the finished instruction come first, then pins.
               if (instr_boundary && (trap_req || break_req))
               begin
                  n.cur_vec = break_req ? `CIE_VEC_BRK : trap_vec;
                  n.cur_class = classify(n.cur_vec, 1'b0, trap_sw | break_req);
                  n.ret_ip = next_ip;
                  n.is_nmi = 1'b0;
                  n.st = ST_PUSH;
               end
               else if (nmi_ok)
               begin
                  n.cur_vec = `CIE_VEC_NMI;
                  n.cur_class = EXC_MASKABLE_IRQ_INPUT;
                  n.ret_ip = string_window ? cur_ip : next_ip;
                  n.is_nmi = 1'b1;
                  n.nmi_pending = 1'b0;
                  n.nmi_active = 1'b1;
                  n.if_flag = 1'b0;
                  n.st = ST_PUSH;
               end
               else if (maskable_irq_input_ok)
               begin
                  n.cur_class = EXC_MASKABLE_IRQ_INPUT;
                  n.ret_ip = string_window ? cur_ip : next_ip;
                  n.is_nmi = 1'b0;
                  n.st = ST_PUSH;
               end
               else if (instr_boundary && fault_req)
               begin
                  // Debug faults arrive here, debug traps on the trap path.
                  n.cur_vec = fault_vec;
                  n.cur_class = classify(fault_vec, 1'b1, 1'b0);
                  // Vector 9 gives no precise address and saves the next address; other faults are restartable.
                  n.ret_ip = (fault_vec == `CIE_VEC_CSO) ? next_ip : cur_ip;
                  n.is_nmi = 1'b0;
                  n.st = ST_PUSH;
               end
               if (n.st == ST_PUSH)
               begin
                  n.push_req = 1'b1;
                  n.push_flags = flags_word;
               end
            end
         end
         ST_PUSH:
         begin
            // Only a maskable interrupt fetches its vector from outside.
            if (r.cur_class == EXC_MASKABLE_IRQ_INPUT && !r.is_nmi)
            begin
               n.inta = 1'b1;
               n.st = ST_ACK;
            end
            else
            begin
               n.table_req = 1'b1;
               n.table_addr = tbl_addr(r.idt_base, r.cur_vec, r.pmode);
               n.st = ST_FETCH;
            end
         end
         ST_ACK:
         begin
            // A rising valid edge avoids reusing a stale answer.
            if (ackv_rise)
            begin
               n.inta = 1'b0;
               n.cur_vec = r.vec_s2;
               if (r.vec_s2 < `CIE_VEC_USER_MIN)
               begin
                  n.bad_vec = 1'b1;
               end
               n.table_req = 1'b1;
               n.table_addr = tbl_addr(r.idt_base, r.vec_s2, r.pmode);
               n.st = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            if (table_valid)
            begin
               if (!r.pmode)
               begin
                  n.if_flag = 1'b0;
               end
               else
               begin
                  unique case (table_gate)
                     GATE_MASKABLE_IRQ_INPUT: n.if_flag = 1'b0;
                     GATE_TRAP: n.if_flag = r.if_flag;
                     GATE_TASK: n.if_flag = table_task_flags[`CIE_FLAGS_IF];
                     default: n.if_flag = 1'b0;
                  endcase
               end
               n.go = 1'b1;
               n.go_handler = table_handler;
               n.st = ST_GO;
            end
         end
         ST_GO: n.st = ST_IDLE;
         default: n.st = ST_IDLE;
      endcase
      // A new edge is kept even when a pending one is taken this cycle.
      if (nmi_edge)
      begin
         n.nmi_pending = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r <= '0;
         r.st <= ST_IDLE;
         r.if_flag <= `CIE_RST_IF;
         r.pmode <= `CIE_RST_PM;
         r.idt_base <= `CIE_RST_IDT;
         r.hready <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   // Outputs come straight from the state register.
   assign hreadyout = r.hready;
   assign hresp = r.hresp;
   assign hrdata = r.hrdata;
   assign push_req = r.push_req;
   assign push_ip = r.ret_ip;
   assign push_flags = r.push_flags;
   assign inta = r.inta;
   assign table_req = r.table_req;
   assign table_addr = r.table_addr;
   assign handler_go = r.go;
   assign handler_addr = r.go_handler;
   assign handler_vec = r.cur_vec;
   assign handler_class = r.cur_class;
   assign if_flag = r.if_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // Nothing starts between boundaries.
   hold_idle_a: assert property ((r.st == ST_IDLE) && !bnd |=> r.st == ST_IDLE)
      else $error("entry started off a boundary");
   // The non-maskable path never runs an acknowledge.
   nmi_noack_a: assert property ((r.st == ST_ACK) |-> !r.is_nmi)
      else $error("acknowledge run for non-maskable");
   // Non-maskable entry clears the enable flag at once.
   nmi_ifclr_a: assert property (idle_take && nmi_ok && !(instr_boundary && (trap_req ||
      break_req)) |=> !r.if_flag && r.cur_vec == 8'h02 && r.nmi_active)
      else $error("non-maskable entry kept enable flag");
   // While active, no pin entry starts; only synchronous events may still enter.
   nmi_block_a: assert property (r.nmi_active && idle_take &&
      !(instr_boundary && (trap_req || break_req || fault_req)) |=> r.st == ST_IDLE)
      else $error("request accepted during non-maskable handler");
   // A nested edge stays pending.
   nmi_pend_a: assert property (nmi_edge |=> r.nmi_pending)
      else $error("non-maskable edge lost");
   // Fault entry other than vector 9 saves the current address.
   fault_ret_a: assert property (idle_take && instr_boundary && !trap_req && !break_req &&
      !nmi_ok && !maskable_irq_input_ok && fault_req && fault_vec != 8'h09
      |=> r.ret_ip == $past(cur_ip) && r.cur_class != EXC_TRAP)
      else $error("fault return address wrong");
   // Trap entry saves the next address.
   trap_ret_a: assert property (idle_take && instr_boundary && trap_req && !break_req
      |=> r.ret_ip == $past(next_ip) && r.cur_vec == $past(trap_vec))
      else $error("trap return address wrong");
   // Breakpoint uses vector 3 as a trap.
   brk_vec_a: assert property (idle_take && instr_boundary && break_req
      |=> r.cur_vec == 8'h03 && r.cur_class == EXC_TRAP)
      else $error("breakpoint vector wrong");
   // Push is followed by acknowledge or table fetch.
   push_seq_a: assert property ((r.st == ST_PUSH) |-> r.push_req ##1
      (r.inta || r.table_req))
      else $error("entry sequence out of order");
   // Table address scales with the mode.
   tbl_addr_a: assert property (r.table_req |-> r.table_addr ==
      r.idt_base + (r.pmode ? {21'h0, r.cur_vec, 3'h0} : {22'h0, r.cur_vec, 2'h0}))
      else $error("table address wrong");
   // Interrupt gate clears the flag.
   gate_if_a: assert property ((r.st == ST_FETCH) && table_valid && r.pmode &&
      table_gate == GATE_MASKABLE_IRQ_INPUT |=> !r.if_flag ##1 r.st == ST_IDLE)
      else $error("interrupt gate kept enable flag");
   // Return restores the flag from the popped flags word.
   interrupt_return_op_if_a: assert property ((r.st == ST_IDLE) && interrupt_return_op_req
      |=> r.if_flag == $past(interrupt_return_op_flags[9]) && !r.nmi_active)
      else $error("return did not restore flag");
endmodule // cie_unit

/* cie_pic_model.sv */
`timescale 1ns/1ps
// Behavioural interrupt controller on the far side of the maskable request and acknowledge.
module cie_pic_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic fire,
   input wire logic [7:0] fire_vec,
   input wire logic [2:0] lag,
   input wire logic inta,
   output logic maskable_irq_input,
   output logic intack_valid,
   output logic [7:0] intack_vector
);
   logic [7:0] held;
   logic [3:0] cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // The vector settles one cycle before valid, because the unit samples both
   // through synchronisers and would otherwise catch a half-changed vector.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         maskable_irq_input <= 1'b0;
         intack_valid <= 1'b0;
         intack_vector <= 8'ha5;
         held <= 8'h00;
         cnt <= 4'h0;
      end
      else
      begin
         if (fire)
         begin
            maskable_irq_input <= 1'b1;
            held <= fire_vec;
         end
         if (inta && !intack_valid)
         begin
            maskable_irq_input <= 1'b0;
            cnt <= cnt + 4'h1;
            if (cnt == {1'b0, lag})
               intack_vector <= held;
            if (cnt == {1'b0, lag} + 4'h1)
               intack_valid <= 1'b1;
         end
         if (!inta && intack_valid)
         begin
            // Released vector lines stop showing the old value.
            intack_valid <= 1'b0;
            intack_vector <= ~held;
            cnt <= 4'h0;
         end
      end
   end
endmodule // cie_pic_model

/* cie_unit_tb.sv */
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_unit_tb;
   import cie_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pm;
   logic [31:0] haddr, hwdata, hrdata, cur_ip, next_ip, flags_word, interrupt_return_op_flags, base, rd;
   logic [31:0] table_task_flags, table_handler, push_ip, push_flags, table_addr, handler_addr;
   logic [1:0] htrans;
   logic [2:0] hsize, lag;
   logic instr_boundary, string_window, trap_req, trap_sw, break_req, fault_req, interrupt_return_op_req;
   logic table_valid, nmi_pin, maskable_irq_input, intack_valid, fire;
   logic push_req, inta, table_req, handler_go, if_flag;
   logic [7:0] trap_vec, fault_vec, intack_vector, handler_vec, fire_vec, v;
   cie_gate_type table_gate;
   cie_class_type handler_class;
   int failures, check_count;
   localparam logic [7:0] fault_list [12] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b,
      8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h08, 8'h09};
   ////////////////////////////////////////////////////////////////////////////////
   cie_unit cie_unit_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instr_boundary, .string_window,
      .cur_ip, .next_ip, .flags_word, .trap_req, .trap_vec, .trap_sw, .break_req, .fault_req,
      .fault_vec, .interrupt_return_op_req, .interrupt_return_op_flags, .table_valid, .table_gate, .table_task_flags,
      .table_handler, .nmi_pin, .maskable_irq_input, .intack_valid, .intack_vector, .push_req,
      .push_ip, .push_flags, .inta, .table_req, .table_addr, .handler_go, .handler_addr,
      .handler_vec, .handler_class, .if_flag);
   cie_pic_model cie_pic_model_inst (.hclk, .hresetn, .fire, .fire_vec, .lag, .inta,
      .maskable_irq_input, .intack_valid, .intack_vector);
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running bus clock, 8 ns period.
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // A hang is cut short well past the expected run length.
   initial
   begin
      #400000;
      failures++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Single word transfer; the wait has no cycle count, only the watchdog ends it.
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= `CIE_HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check(32'(hresp), 32'h0, "bus response");
   endtask
   // One boundary pulse carrying the synchronous event requests: k is fault, break, trap.
   task automatic bnd(input logic win, input logic [2:0] k, input logic [7:0] tv,
      input logic [7:0] fv);
      @(posedge hclk);
      cur_ip <= $urandom();
      next_ip <= $urandom();
      flags_word <= $urandom();
      instr_boundary <= !win;
      string_window <= win;
      trap_req <= k[0];
      trap_vec <= tv;
      trap_sw <= (tv > 8'h20);
      break_req <= k[1];
      fault_req <= k[2];
      fault_vec <= fv;
      @(posedge hclk);
      instr_boundary <= 1'b0;
      string_window <= 1'b0;
      trap_req <= 1'b0;
      break_req <= 1'b0;
      fault_req <= 1'b0;
   endtask
   // Follows one entry to its handler, answering the table lookup with gate g.
   task automatic entry(input logic [7:0] ev, input cie_class_type ec, input logic use_next,
      input cie_gate_type g, input logic ack, input logic eif);
      int n;
      logic saw;
      logic [31:0] h, tf;
      saw = 1'b0;
      h = $urandom();
      tf = $urandom();
      for (n = 0; n < 30 && push_req !== 1'b1; n++)
         @(posedge hclk);
      check(push_ip, use_next ? next_ip : cur_ip, "return address");
      check(push_flags, flags_word, "pushed flags");
      for (n = 0; n < 40 && table_req !== 1'b1; n++)
      begin
         @(posedge hclk);
         saw = saw | (inta === 1'b1);
      end
      check(32'(saw), 32'(ack), "acknowledge run");
      check(table_addr, base + (32'(ev) << (pm ? 3 : 2)), "table address");
      repeat ($urandom_range(2)) @(posedge hclk);
      table_valid <= 1'b1;
      table_gate <= g;
      table_task_flags <= tf;
      table_handler <= h;
      @(posedge hclk);
      table_valid <= 1'b0;
      table_handler <= ~h;
      for (n = 0; n < 30 && handler_go !== 1'b1; n++)
         @(posedge hclk);
      check(handler_addr, h, "handler address");
      check({24'h0, handler_vec}, {24'h0, ev}, "vector");
      check(32'(handler_class), 32'(ec), "class");
      check(32'(if_flag), 32'((pm && g == GATE_TASK) ? tf[9] : eif), "flag");
   endtask
   task automatic quiet();
      logic seen;
      seen = 1'b0;
      repeat (12)
      begin
         @(posedge hclk);
         seen = seen | (push_req === 1'b1);
      end
      check(32'(seen), 32'h0, "entry while blocked");
   endtask
   task automatic raise(input logic [7:0] fv);
      @(posedge hclk);
      fire <= 1'b1;
      fire_vec <= fv;
      lag <= 3'($urandom());
      @(posedge hclk);
      fire <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic nmi();
      @(posedge hclk);
      nmi_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      nmi_pin <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic interrupt_return_op(input logic [31:0] f);
      @(posedge hclk);
      interrupt_return_op_req <= 1'b1;
      interrupt_return_op_flags <= f;
      @(posedge hclk);
      interrupt_return_op_req <= 1'b0;
      interrupt_return_op_flags <= ~f;
      @(posedge hclk);
      check(32'(if_flag), 32'(f[9]), "restored flag");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: registers, real-mode traps and faults, then protected-mode interrupts.
   initial
   begin
      {hsel, hwrite, instr_boundary, string_window, trap_req, trap_sw, break_req} = '0;
      {fault_req, interrupt_return_op_req, table_valid, nmi_pin, fire, hresetn, pm} = '0;
      {haddr, hwdata, cur_ip, next_ip, flags_word, interrupt_return_op_flags, table_task_flags} = '0;
      {table_handler, htrans, hsize, lag, trap_vec, fault_vec, fire_vec} = '0;
      table_gate = GATE_MASKABLE_IRQ_INPUT;
      void'($urandom(6851));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `CIE_OFF_CTRL, 32'h0);
      check(rd, 32'h0, "control after reset");
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0, "unmapped read");
      base = $urandom() & 32'hffff_f800;
      ahb(1'b1, `CIE_OFF_IDT, base);
      ahb(1'b0, `CIE_OFF_IDT, 32'h0);
      check(rd, base, "table base");
      for (int i = 0; i < 12; i++)
      begin
         v = (i == 0) ? 8'h21 : (i == 1) ? 8'hff : 8'($urandom_range(255, 33));
         bnd(1'b0, 3'b001, v, 8'h00);
         entry(v, EXC_TRAP, 1'b1, GATE_TRAP, 1'b0, 1'b0);
         v = fault_list[i];
         bnd(1'b0, 3'b100, 8'h00, v);
         entry(v, (v == 8'h08 || v == 8'h09) ? EXC_ABORT : EXC_FAULT, v == 8'h09, GATE_TRAP,
            1'b0, 1'b0);
      end
      bnd(1'b0, 3'b010, 8'h00, 8'h00);
      entry(`CIE_VEC_BRK, EXC_TRAP, 1'b1, GATE_TRAP, 1'b0, 1'b0);
      bnd(1'b0, 3'b101, 8'h01, 8'h01);
      entry(8'h01, EXC_TRAP, 1'b1, GATE_TRAP, 1'b0, 1'b0);
      bnd(1'b0, 3'b100, 8'h00, 8'h01);
      entry(8'h01, EXC_FAULT, 1'b0, GATE_TRAP, 1'b0, 1'b0);
      ahb(1'b0, `CIE_OFF_RET, 32'h0);
      check(rd, cur_ip, "saved return");
      // Protected mode with the enable flag set; a trap gate would keep it, so NMI must clear it.
      pm = 1'b1;
      ahb(1'b1, `CIE_OFF_CTRL, 32'h3);
      nmi();
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      entry(`CIE_VEC_NMI, EXC_MASKABLE_IRQ_INPUT, 1'b1, GATE_TRAP, 1'b0, 1'b0);
      nmi();
      raise(8'h40);
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      quiet();
      ahb(1'b0, `CIE_OFF_STAT, 32'h0);
      check(32'(rd[9:8]), 32'h3, "nested nmi held");
      interrupt_return_op($urandom());
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      entry(`CIE_VEC_NMI, EXC_MASKABLE_IRQ_INPUT, 1'b1, GATE_TRAP, 1'b0, 1'b0);
      interrupt_return_op($urandom() | 32'h200);
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      entry(8'h40, EXC_MASKABLE_IRQ_INPUT, 1'b1, GATE_TRAP, 1'b1, 1'b1);
      v = 8'($urandom_range(255, 33));
      raise(v);
      bnd(1'b1, 3'b000, 8'h00, 8'h00);
      entry(v, EXC_MASKABLE_IRQ_INPUT, 1'b0, GATE_TASK, 1'b1, 1'b0);
      ahb(1'b1, `CIE_OFF_CTRL, 32'h3);
      raise(8'h90);
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      entry(8'h90, EXC_MASKABLE_IRQ_INPUT, 1'b1, GATE_MASKABLE_IRQ_INPUT, 1'b1, 1'b0);
      raise(8'h14);
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      quiet();
      ahb(1'b1, `CIE_OFF_CTRL, 32'h3);
      bnd(1'b0, 3'b000, 8'h00, 8'h00);
      entry(8'h14, EXC_MASKABLE_IRQ_INPUT, 1'b1, GATE_MASKABLE_IRQ_INPUT, 1'b1, 1'b0);
      ahb(1'b0, `CIE_OFF_STAT, 32'h0);
      check(32'(rd[10]), 32'h1, "reserved vector flagged");
      tally_and_finish();
   end
endmodule // cie_unit_tb
